// file: testbench/hub_desc_assertions.sv
// Port assertions for the root hub descriptor block
`timescale 1ns/1ns
module hub_desc_assertions #(
  parameter int UNIT_CYCLES = 4
) (
  // Clock, reset and commands
  input wire logic                  mclk_in,
  input wire logic                  srst_in,
  input wire hub_desc_pkg::cmd_type cmd_in,
  input wire logic                  operational_state_in,
  // Watched outputs
  input wire logic                  rd_valid_out,
  input wire logic [31:0]           rd_data_out,
  input wire logic                  access_error_out,
  input wire logic                  status_wr_out,
  input wire logic [7:0]            status_wr_code_out,
  input wire logic [1:0]            port_power_out,
  input wire logic [1:0]            port_ready_out,
  input wire logic                  oc_global_out,
  input wire logic [1:0]            oc_port_out
);
  logic st_cmd;
  logic prot_off_q, prot_off_d, sw_off_q, sw_off_d;
  // Shadow copies of the protection-off and switch-off bits, updated on whole-word writes only
  assign st_cmd = cmd_in.valid && cmd_in.dword && cmd_in.code inside {8'h94, 8'h95, 8'h96};
  always_comb begin
    prot_off_d = prot_off_q;
    sw_off_d   = sw_off_q;
    if (cmd_in.valid && cmd_in.dword && cmd_in.code == hub_desc_pkg::CODE_WR_FIRST) begin
      prot_off_d = cmd_in.data[hub_desc_pkg::NO_PROT_BIT];
      sw_off_d   = cmd_in.data[hub_desc_pkg::NO_SWITCH_BIT];
    end
  end
  always_ff @(posedge mclk_in) begin
    prot_off_q <= srst_in ? hub_desc_pkg::RST_NO_PROT : prot_off_d;
    sw_off_q   <= srst_in ? hub_desc_pkg::RST_NO_SWITCH : sw_off_d;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  sequence s_wr_a;
    cmd_in.valid && cmd_in.dword && cmd_in.code == hub_desc_pkg::CODE_WR_FIRST;
  endsequence
  sequence s_rd_a;
    cmd_in.valid && cmd_in.dword && cmd_in.code == hub_desc_pkg::CODE_RD_FIRST;
  endsequence
  chk_read_answer: assert property (s_rd_a |=> rd_valid_out && !access_error_out)
    else $error("first word read not answered");
  chk_write_readback: assert property (s_wr_a ##1 !cmd_in.valid ##1 s_rd_a |=>
    rd_data_out[31:24] == $past(cmd_in.data[31:24], 3)) else $error("delay byte lost");
  chk_partial_refused: assert property (cmd_in.valid && !cmd_in.dword |=>
    access_error_out && !rd_valid_out && !status_wr_out) else $error("partial access taken");
  chk_status_gated: assert property (st_cmd && !operational_state_in |=>
    access_error_out && !status_wr_out) else $error("status write not gated");
  chk_status_fwd: assert property (st_cmd && operational_state_in |=>
    status_wr_out && status_wr_code_out == $past(cmd_in.code)) else $error("status lost");
  chk_compound_zero: assert property (s_rd_a |=>
    !rd_data_out[10] && rd_data_out[23:13] == 11'h0) else $error("fixed bits not zero");
  chk_port_count: assert property (s_rd_a |=>
    rd_data_out[1:0] == 2'h2 && rd_data_out[7:2] == 6'h0) else $error("port count wrong");
  chk_prot_silent: assert property (prot_off_q [*4] |-> !oc_global_out && oc_port_out == 2'h0)
    else $error("overcurrent reported while disabled");
  chk_always_powered: assert property (sw_off_q [*3] |-> port_power_out == 2'h3)
    else $error("ports not held powered");
  chk_ready_drop: assert property (!port_power_out[0] [*2] |-> !port_ready_out[0])
    else $error("power good without power");
endmodule // hub_desc_assertions
bind root_hub_descriptor_config hub_desc_assertions #(.UNIT_CYCLES(UNIT_CYCLES))
  u_hub_desc_assertions (.mclk_in, .srst_in, .cmd_in, .operational_state_in, .rd_valid_out,
  .rd_data_out, .access_error_out, .status_wr_out, .status_wr_code_out, .port_power_out,
  .port_ready_out, .oc_global_out, .oc_port_out);

// file: testbench/tb.sv
// Self-checking bench for the root hub descriptor block
`timescale 1ns/1ns
module tb;
  localparam int UNIT = 4;
  logic                      mclk_in = 1'h0;
  logic                      srst_in = 1'h1;
  hub_desc_pkg::cmd_type     cmd_in = '0;
  logic                      operational_state_in = 1'h0;
  hub_desc_pkg::pwr_cmd_type pwr_cmd_in = '0;
  logic [1:0]                oc_pin_n_in = 2'h3;
  logic                      rd_valid_out, access_error_out, status_wr_out, oc_global_out;
  logic [31:0]               rd_data_out, status_wr_data_out, wd;
  logic [7:0]                status_wr_code_out;
  logic [1:0]                port_power_out, port_ready_out, oc_port_out;
  logic                      op_v = 1'h0;
  int                        error_cnt = 0;
  int                        checks_done = 0;
  int                        seed = 5;
  int                        reg_a, reg_b, n;
  logic [5:0]                pv [5] = '{6'h10, 6'h02, 6'h20, 6'h01, 6'h08};
  logic [1:0]                pe [5] = '{2'h2, 2'h0, 2'h1, 2'h1, 2'h3};
  logic [31:0]               ov [4] = '{32'h0, 32'h800, 32'h1800, 32'h1000};
  logic [2:0]                oe [4] = '{3'h4, 3'h1, 3'h0, 3'h0};
  // Free-running core clock
  always #25 mclk_in = ~mclk_in;
  root_hub_descriptor_config #(.UNIT_CYCLES(UNIT)) u_root_hub_descriptor_config (
    .mclk_in, .srst_in, .cmd_in, .operational_state_in, .pwr_cmd_in, .oc_pin_n_in,
    .rd_valid_out, .rd_data_out, .access_error_out, .status_wr_out, .status_wr_code_out,
    .status_wr_data_out, .port_power_out, .port_ready_out, .oc_global_out, .oc_port_out);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  // Reset also rebuilds the model's view of both descriptor words
  task automatic do_reset();
    @(posedge mclk_in);
    srst_in <= 1'h1;
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'h0;
    reg_a = 32'h0A000902;
    reg_b = 0;
  endtask
  // One command, valid for one cycle; outputs are settled on return
  task automatic bus(input logic [7:0] code, input logic [31:0] data, input logic dw);
    @(posedge mclk_in);
    cmd_in <= {1'h1, dw, code, data};
    operational_state_in <= op_v;
    // Request drops at the edge that takes it; outputs read once settled
    @(posedge mclk_in);
    cmd_in.valid <= 1'h0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] code, input logic [31:0] exp);
    bus(code, 32'h0, 1'h1);
    chk("read answer", 32'h1, 32'(rd_valid_out));
    chk("read word", exp, rd_data_out);
  endtask
  // Model keeps writable fields; fixed and reserved places read back as zero, port count as two
  task automatic wr_a(input logic [31:0] d);
    bus(hub_desc_pkg::CODE_WR_FIRST, d, 1'h1);
    reg_a = (d & 32'hFF001B00) | 32'h2;
  endtask
  task automatic pwr(input logic [5:0] v, input logic [1:0] exp);
    @(posedge mclk_in);
    pwr_cmd_in <= v;
    @(posedge mclk_in);
    pwr_cmd_in <= '0;
    #1;
    chk("port power", 32'(exp), 32'(port_power_out));
  endtask
  initial begin
    do_reset();
    rd_chk(8'h12, reg_a);
    rd_chk(8'h13, 32'h0);
    for (int i = 0; i < 8; i++) begin
      op_v = 1'($random(seed));
      wr_a($random(seed));
      rd_chk(8'h12, reg_a);
    end
    // Partial-width accesses change nothing
    bus(8'h92, ~reg_a, 1'h0);
    chk("partial write", 32'h1, 32'(access_error_out));
    bus(8'h12, 32'h0, 1'h0);
    chk("partial read", 32'h0, 32'(rd_valid_out));
    rd_chk(8'h12, reg_a);
    for (int c = 8'h94; c <= 8'h96; c++) begin
      for (int o = 0; o < 2; o++) begin
        op_v = 1'(o);
        wd = $random(seed);
        bus(8'(c), wd, 1'h1);
        chk("status pulse", 32'(o), 32'(status_wr_out));
        chk("status refusal", 32'(1 - o), 32'(access_error_out));
        if (o == 1) chk("status data", wd, status_wr_data_out);
        if (o == 1) chk("status code", 32'(c), 32'(status_wr_code_out));
      end
    end
    op_v = 1'h0;
    bus(8'h14, 32'h0, 1'h1);
    chk("unknown answer", 32'h0, 32'({rd_valid_out, access_error_out, status_wr_out}));
    // Ganged switching with a two-unit power-good delay
    wr_a(32'h02000000);
    pwr(6'h10, 2'h0);
    tick(2);
    chk("ready drop", 32'h0, 32'(port_ready_out));
    pwr(6'h20, 2'h3);
    n = 0;
    while (port_ready_out !== 2'h3 && n < 40) begin
      tick(1);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      end_of_test();
    end
    chk("ready delay", 32'h1, 32'(n >= 2 * UNIT && n <= 2 * UNIT + 4));
    pwr(6'h03, 2'h3);
    // Individual switching, only port two masked
    bus(8'h93, 32'hFFFDFFFF, 1'h1);
    reg_b = 32'h00040006;
    rd_chk(8'h13, reg_b);
    wr_a(32'h00000100);
    for (int i = 0; i < 5; i++) pwr(pv[i], pe[i]);
    wr_a(32'h00000200);
    pwr(6'h10, 2'h3);
    // Report mode cleared before it is set, then protection turned off
    @(posedge mclk_in);
    oc_pin_n_in <= 2'h2;
    for (int i = 0; i < 4; i++) begin
      wr_a(ov[i]);
      tick(5);
      chk("overcurrent", 32'(oe[i]), 32'({oc_global_out, oc_port_out}));
    end
    @(posedge mclk_in);
    oc_pin_n_in <= 2'h3;
    do_reset();
    rd_chk(8'h12, reg_a);
    chk("power after reset", 32'h0, 32'(port_power_out));
    end_of_test();
  end
endmodule // tb

// file: verilog/hub_desc_pkg.sv
// Package with constants and carrier types for the root hub descriptor block
// Notes on behaviour
// - Root hub registers accessed only as whole doublewords
// - Descriptor writes accepted in every controller state
// - Hub and port status writes only when operational
// - Read code 12h, write code 92h for descriptor
// - Bits 31:24 power-good delay, 2 ms units
// - Bit 12 set disables all overcurrent reporting
// - Bit 11 selects collective or per-port overcurrent
// - Overcurrent mode resets to power switching mode
// - Compound device bit always reads zero
// - Bit 9 set keeps ports always powered
// - Bit 8 selects ganged or individual switching
// - Bits 1:0 read-only port count, maximum two
// - Power mask bits 18:16 of second descriptor
package hub_desc_pkg;

  // Command codes on the shared host bus
  localparam logic [7:0] CODE_RD_FIRST      = 8'h12;
  localparam logic [7:0] CODE_WR_FIRST      = 8'h92;
  localparam logic [7:0] CODE_RD_SECOND     = 8'h13;
  localparam logic [7:0] CODE_WR_SECOND     = 8'h93;
  localparam logic [7:0] CODE_WR_HUB_STATUS = 8'h94;
  localparam logic [7:0] CODE_WR_PORT_ONE   = 8'h95;
  localparam logic [7:0] CODE_WR_PORT_TWO   = 8'h96;

  // Field positions of the first descriptor register
  localparam int DELAY_LSB       = 24;
  localparam int DELAY_MSB       = 31;
  localparam int NO_PROT_BIT     = 12;
  localparam int OC_MODE_BIT     = 11;
  localparam int COMPOUND_BIT    = 10;
  localparam int NO_SWITCH_BIT   = 9;
  localparam int SWITCH_MODE_BIT = 8;
  localparam int PORT_CNT_LSB    = 0;
  localparam int PORT_CNT_MSB    = 1;

  // Field positions of the second descriptor register
  localparam int PWR_MASK_LSB = 16;
  localparam int PWR_MASK_MSB = 18;
  localparam int DR_LSB   = 0;
  localparam int DR_MSB   = 2;

  // Implementation-specific reset values
  localparam logic [7:0] RST_DELAY       = 8'h0A;
  localparam logic       RST_NO_PROT     = 1'b0;
  localparam logic       RST_NO_SWITCH   = 1'b0;
  localparam logic       RST_SWITCH_MODE = 1'b1;
  localparam logic [1:0] RST_PORT_CNT    = 2'h2;
  localparam logic [2:0] RST_PWR_MASK    = 3'h0;
  localparam logic [2:0] RST_DR          = 3'h0;
  localparam int         NUM_PORTS       = 2;

  // Power-good time unit and its cycle count at the core clock
  localparam int PG_UNIT_US     = 2000;
  localparam int CLK_KHZ        = 20000;
  localparam int PG_UNIT_CYCLES = (PG_UNIT_US * CLK_KHZ + 999) / 1000;

  // One register command from the bus interface
  typedef struct packed {
    logic        valid;
    logic        dword;
    logic [7:0]  code;
    logic [31:0] data;
  } cmd_type;

  // Decoded power commands from hub and port status logic
  typedef struct packed {
    logic       global_set;
    logic       global_clear;
    logic [1:0] port_set;
    logic [1:0] port_clear;
  } pwr_cmd_type;

endpackage

// file: verilog/power_good_timer.sv
// Per-port power-on to power-good delay timer
`timescale 1ns/1ns
module power_good_timer #(
  parameter int UNIT_CYCLES = hub_desc_pkg::PG_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  // Control
  input  wire logic       start_in,
  input  wire logic       powered_in,
  input  wire logic [7:0] delay_in,
  // Status
  output logic            ready_out
);

  logic [31:0] pre_q;
  logic [31:0] pre_d;
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic        ready_q;
  logic        ready_d;
  logic        tick;

  // Prescaler restarts with each power-on so the first unit is whole
  always_comb begin
    pre_d   = pre_q;
    count_d = count_q;
    ready_d = ready_q;
    tick    = (pre_q == 32'(UNIT_CYCLES - 1));
    if (!powered_in) begin
      pre_d   = 32'h0;
      count_d = 8'h00;
      ready_d = 1'b0;
    end else if (start_in) begin
      pre_d   = 32'h0;
      count_d = delay_in;
      ready_d = 1'b0;
    end else if (!ready_q) begin
      pre_d = tick ? 32'h0 : pre_q + 32'h1;
      if (count_q == 8'h00) begin
        ready_d = 1'b1;
      end else if (tick) begin
        count_d = count_q - 8'h01;
      end
    end
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pre_q   <= 32'h0;
      count_q <= 8'h00;
      ready_q <= 1'b0;
    end else begin
      pre_q   <= pre_d;
      count_q <= count_d;
      ready_q <= ready_d;
    end
  end

  assign ready_out = ready_q;

endmodule // power_good_timer

// file: verilog/root_hub_descriptor_config.sv
// Root hub descriptor registers, port power switching and overcurrent reporting
`timescale 1ns/1ns
module root_hub_descriptor_config #(
  parameter int UNIT_CYCLES = hub_desc_pkg::PG_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      srst_in,
  // Register commands from the bus interface
  input  wire hub_desc_pkg::cmd_type     cmd_in,
  input  wire logic                      operational_state_in,
  // Power commands from hub and port status logic
  input  wire hub_desc_pkg::pwr_cmd_type pwr_cmd_in,
  // Overcurrent pins, active low, asynchronous
  input  wire logic [1:0]                oc_pin_n_in,
  // Read answer
  output logic                           rd_valid_out,
  output logic [31:0]                    rd_data_out,
  output logic                           access_error_out,
  // Gated status register writes
  output logic                           status_wr_out,
  output logic [7:0]                     status_wr_code_out,
  output logic [31:0]                    status_wr_data_out,
  // Port power and power-good
  output logic [1:0]                     port_power_out,
  output logic [1:0]                     port_ready_out,
  // Overcurrent reports
  output logic                           oc_global_out,
  output logic [1:0]                     oc_port_out
);

  // Descriptor state
  logic [7:0] delay_q;
  logic [7:0] delay_d;
  logic       no_prot_q;
  logic       no_prot_d;
  logic       oc_mode_q;
  logic       oc_mode_d;
  logic       no_switch_q;
  logic       no_switch_d;
  logic       switch_mode_q;
  logic       switch_mode_d;
  logic [1:0] pwr_mask_q;
  logic [1:0] pwr_mask_d;
  logic [1:0] dr_q;
  logic [1:0] dr_d;

  // Port power state
  logic [1:0] power_q;
  logic [1:0] power_d;
  logic [1:0] power_start;

  // Output registers
  logic        rd_valid_q;
  logic        rd_valid_d;
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;
  logic        err_q;
  logic        err_d;
  logic        stwr_q;
  logic        stwr_d;
  logic [7:0]  stcode_q;
  logic [7:0]  stcode_d;
  logic [31:0] stdata_q;
  logic [31:0] stdata_d;
  logic [1:0]  ready_q;
  logic [1:0]  ready_d;
  logic        ocg_q;
  logic        ocg_d;
  logic [1:0]  ocp_q;
  logic [1:0]  ocp_d;

  // Decode helpers
  logic       cmd_ok;
  logic       bad_width;
  logic       is_status_wr;
  logic [1:0] timer_ready;
  logic [1:0] oc_n_sync;
  logic [1:0] oc_active;

  // Assemble the first descriptor word
  function automatic logic [31:0] pack_first(input logic [7:0] pg, input logic no_prot,
                                             input logic oc_mode, input logic no_switch,
                                             input logic switch_mode);
    logic [31:0] w;
    w = 32'h0;
    w[hub_desc_pkg::DELAY_MSB:hub_desc_pkg::DELAY_LSB] = pg;
    w[hub_desc_pkg::NO_PROT_BIT] = no_prot;
    w[hub_desc_pkg::OC_MODE_BIT] = oc_mode;
    w[hub_desc_pkg::COMPOUND_BIT] = 1'b0;
    w[hub_desc_pkg::NO_SWITCH_BIT] = no_switch;
    w[hub_desc_pkg::SWITCH_MODE_BIT] = switch_mode;
    w[hub_desc_pkg::PORT_CNT_MSB:hub_desc_pkg::PORT_CNT_LSB] = hub_desc_pkg::RST_PORT_CNT;
    return w;
  endfunction

  // Assemble the second descriptor word; bit 0 of each field reads zero
  function automatic logic [31:0] pack_second(input logic [1:0] mask, input logic [1:0] rem);
    logic [31:0] w;
    w = 32'h0;
    w[hub_desc_pkg::PWR_MASK_MSB:hub_desc_pkg::PWR_MASK_LSB] = {mask, 1'b0};
    w[hub_desc_pkg::DR_MSB:hub_desc_pkg::DR_LSB] = {rem, 1'b0};
    return w;
  endfunction

  // Next power state of one port from the switching configuration
  function automatic logic next_power(input logic cur, input logic always_on,
                                      input logic per_port,
                                      input logic masked, input logic gset,
                                      input logic gclr, input logic pset,
                                      input logic pclr);
    logic n;
    n = cur;
    if (always_on) begin
      n = 1'b1;
    end else if (per_port && masked) begin
      n = pset ? 1'b1 : (pclr ? 1'b0 : cur);
    end else begin
      n = gset ? 1'b1 : (gclr ? 1'b0 : cur);
    end
    return n;
  endfunction

  // Overcurrent pins come from outside the clock domain
  sync_two #(
    .WIDTH (2)
  ) u_oc_sync (
    .mclk_in    (mclk_in),
    .srst_in    (srst_in),
    .async_in   (oc_pin_n_in),
    .rst_val_in (2'h3),
    .sync_out   (oc_n_sync)
  );

  assign oc_active = ~oc_n_sync;

  // Command qualification shared by all groups
  // whole doubleword only
  always_comb begin
    cmd_ok       = cmd_in.valid && cmd_in.dword;
    bad_width    = cmd_in.valid && !cmd_in.dword;
    is_status_wr = (cmd_in.code == hub_desc_pkg::CODE_WR_HUB_STATUS) ||
                   (cmd_in.code == hub_desc_pkg::CODE_WR_PORT_ONE) ||
                   (cmd_in.code == hub_desc_pkg::CODE_WR_PORT_TWO);
  end

  // Descriptor register next values
  always_comb begin
    delay_d       = delay_q;
    no_prot_d     = no_prot_q;
    oc_mode_d     = oc_mode_q;
    no_switch_d   = no_switch_q;
    switch_mode_d = switch_mode_q;
    pwr_mask_d    = pwr_mask_q;
    dr_d          = dr_q;
    if (cmd_ok && cmd_in.code == hub_desc_pkg::CODE_WR_FIRST) begin
      delay_d       = cmd_in.data[hub_desc_pkg::DELAY_MSB:hub_desc_pkg::DELAY_LSB];
      no_prot_d     = cmd_in.data[hub_desc_pkg::NO_PROT_BIT];
      oc_mode_d     = cmd_in.data[hub_desc_pkg::OC_MODE_BIT];
      no_switch_d   = cmd_in.data[hub_desc_pkg::NO_SWITCH_BIT];
      switch_mode_d = cmd_in.data[hub_desc_pkg::SWITCH_MODE_BIT];
    end
    if (cmd_ok && cmd_in.code == hub_desc_pkg::CODE_WR_SECOND) begin
      pwr_mask_d = cmd_in.data[hub_desc_pkg::PWR_MASK_MSB:hub_desc_pkg::PWR_MASK_LSB + 1];
      dr_d   = cmd_in.data[hub_desc_pkg::DR_MSB:hub_desc_pkg::DR_LSB + 1];
    end
  end

  // Descriptor registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      delay_q       <= hub_desc_pkg::RST_DELAY;
      no_prot_q     <= hub_desc_pkg::RST_NO_PROT;
      oc_mode_q     <= hub_desc_pkg::RST_SWITCH_MODE;
      no_switch_q   <= hub_desc_pkg::RST_NO_SWITCH;
      switch_mode_q <= hub_desc_pkg::RST_SWITCH_MODE;
      pwr_mask_q    <= hub_desc_pkg::RST_PWR_MASK[2:1];
      dr_q          <= hub_desc_pkg::RST_DR[2:1];
    end else begin
      delay_q       <= delay_d;
      no_prot_q     <= no_prot_d;
      oc_mode_q     <= oc_mode_d;
      no_switch_q   <= no_switch_d;
      switch_mode_q <= switch_mode_d;
      pwr_mask_q    <= pwr_mask_d;
      dr_q          <= dr_d;
    end
  end

  // Port power next values; ganged mode treats every port as unmasked
  // mask picks command source
  always_comb begin
    for (int p = 0; p < hub_desc_pkg::NUM_PORTS; p++) begin
      power_d[p] = next_power(power_q[p], no_switch_q, switch_mode_q, pwr_mask_q[p],
                              pwr_cmd_in.global_set, pwr_cmd_in.global_clear,
                              pwr_cmd_in.port_set[p], pwr_cmd_in.port_clear[p]);
    end
    power_start = power_d & ~power_q;
  end

  // Port power registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      power_q <= 2'h0;
    end else begin
      power_q <= power_d;
    end
  end

  // One delay timer per port, started on each power-on
  // wait count units
  for (genvar g = 0; g < hub_desc_pkg::NUM_PORTS; g++) begin : g_timer
    power_good_timer #(
      .UNIT_CYCLES (UNIT_CYCLES)
    ) u_timer (
      .mclk_in    (mclk_in),
      .srst_in    (srst_in),
      .start_in   (power_start[g]),
      .powered_in (power_q[g] | power_start[g]),
      .delay_in   (delay_q),
      .ready_out  (timer_ready[g])
    );
  end

  // Bus answers, status write gating and overcurrent reports
  always_comb begin
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_q;
    err_d      = bad_width;
    stwr_d     = 1'b0;
    stcode_d   = stcode_q;
    stdata_d   = stdata_q;
    if (cmd_ok && cmd_in.code == hub_desc_pkg::CODE_RD_FIRST) begin
      rd_valid_d = 1'b1;
      rd_data_d  = pack_first(delay_q, no_prot_q, oc_mode_q, no_switch_q, switch_mode_q);
    end else if (cmd_ok && cmd_in.code == hub_desc_pkg::CODE_RD_SECOND) begin
      rd_valid_d = 1'b1;
      rd_data_d  = pack_second(pwr_mask_q, dr_q);
    end
    if (cmd_ok && is_status_wr) begin
      if (operational_state_in) begin
        stwr_d   = 1'b1;
        stcode_d = cmd_in.code;
        stdata_d = cmd_in.data;
      end else begin
        err_d = 1'b1;
      end
    end
    ready_d = timer_ready & power_q;
    if (no_prot_q) begin
      ocg_d = 1'b0;
      ocp_d = 2'h0;
    end else if (oc_mode_q) begin
      ocg_d = 1'b0;
      ocp_d = oc_active;
    end else begin
      ocg_d = |oc_active;
      ocp_d = 2'h0;
    end
  end

  // Output registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 32'h0;
      err_q      <= 1'b0;
      stwr_q     <= 1'b0;
      stcode_q   <= 8'h00;
      stdata_q   <= 32'h0;
      ready_q    <= 2'h0;
      ocg_q      <= 1'b0;
      ocp_q      <= 2'h0;
    end else begin
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
      err_q      <= err_d;
      stwr_q     <= stwr_d;
      stcode_q   <= stcode_d;
      stdata_q   <= stdata_d;
      ready_q    <= ready_d;
      ocg_q      <= ocg_d;
      ocp_q      <= ocp_d;
    end
  end

  // Every output is a flop
  assign rd_valid_out       = rd_valid_q;
  assign rd_data_out        = rd_data_q;
  assign access_error_out   = err_q;
  assign status_wr_out      = stwr_q;
  assign status_wr_code_out = stcode_q;
  assign status_wr_data_out = stdata_q;
  assign port_power_out     = power_q;
  assign port_ready_out     = ready_q;
  assign oc_global_out      = ocg_q;
  assign oc_port_out        = ocp_q;

endmodule // root_hub_descriptor_config

// file: verilog/sync_two.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ns
module sync_two #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             srst_in,
  // Asynchronous level and its synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Reset is synchronous, so a value port may be loaded
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_q <= rst_val_in;
      sync_q <= rst_val_in;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // sync_two
